// File: shared/padet_pkg.sv
/*
  Shared constants and types for the power activity detection unit:
  index/data port addresses, register indexes, field positions, write
  masks, reset values, power states and source bundles.
  Assumes an 8-bit IO port bus with 16-bit port addresses.
*/
package padet_pkg;

  // Index/data port pair
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA = 16'h0023;

  // Register indexes
  localparam logic [7:0] IDX_SYS_RANGE = 8'h63;
  localparam logic [7:0] IDX_SYS_IRQ = 8'h64;
  localparam logic [7:0] IDX_HK_SRC = 8'h65;
  localparam logic [7:0] IDX_HK_RANGE = 8'h66;
  localparam logic [7:0] IDX_INACT = 8'h67;
  localparam logic [7:0] IDX_TRAP = 8'h69;
  localparam logic [7:0] IDX_TRAP_UP = 8'h6A;
  localparam logic [7:0] IDX_RANGE_HI = 8'h6B;
  localparam logic [7:0] IDX_RANGE_LO = 8'h6C;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Writable bits; the others read as zero
  localparam logic [7:0] MASK_SYS_RANGE = 8'h20;
  localparam logic [7:0] MASK_SYS_IRQ = 8'hE0;
  localparam logic [7:0] MASK_HK_SRC = 8'hFC;
  localparam logic [7:0] MASK_HK_RANGE = 8'h20;
  localparam logic [7:0] MASK_PERIPH = 8'hFC;
  localparam logic [7:0] MASK_TRAP_UP = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // Field positions
  localparam int BIT_RANGE_EN = 5;
  localparam int BIT_SYS_UPPER_IRQ = 7;
  localparam int BIT_SYS_IRQ0 = 6;
  localparam int BIT_SYS_NMI = 5;
  localparam int BIT_HK_DRQ = 7;
  localparam int BIT_HK_BUS_MASTER = 6;
  localparam int BIT_HK_KEYBOARD = 5;
  localparam int BIT_HK_UPPER_IRQ = 4;
  localparam int BIT_HK_IRQ0 = 3;
  localparam int BIT_HK_NMI = 2;
  localparam int BIT_PER_PARALLEL = 7;
  localparam int BIT_PER_SERIAL = 6;
  localparam int BIT_PER_KEYBOARD = 5;
  localparam int BIT_PER_FLOPPY = 4;
  localparam int BIT_PER_HARD_DISK = 3;
  localparam int BIT_PER_RANGE = 2;
  localparam int BIT_RANGE_MEM = 0;

  // Sampled source vector layout
  localparam int NUM_SRC = 24;
  localparam int SRC_HARD_DISK = 0;
  localparam int SRC_FLOPPY = 1;
  localparam int SRC_KEYBOARD = 2;
  localparam int SRC_SERIAL = 3;
  localparam int SRC_PARALLEL = 4;
  localparam int SRC_BUS_MASTER = 5;
  localparam int SRC_DRQ = 6;
  localparam int SRC_IRQ0 = 7;
  localparam int SRC_NMI = 8;
  localparam int SRC_UPPER_IRQ_LO = 9;
  localparam int SRC_UPPER_IRQ_HI = 23;

  typedef enum logic [2:0] {
    PADET_PWR_ON = 3'b000,
    PADET_PWR_DOZE = 3'b001,
    PADET_PWR_STANDBY = 3'b010,
    PADET_PWR_HOUSEKEEP = 3'b011,
    PADET_PWR_SUSPEND = 3'b100
  } padet_power_t;

  typedef struct packed {
    logic [15:1] upper_interrupt_lines_src;
    logic nmi_src;
    logic irq0_src;
    logic drq_src;
    logic bus_master_src;
    logic parallel_port_src;
    logic serial_port_src;
    logic keyboard_src;
    logic floppy_src;
    logic hard_disk_src;
  } padet_src_t;

  typedef struct packed {
    logic valid;
    logic is_mem;
    logic [31:0] addr;
  } padet_cycle_t;

  typedef struct packed {
    logic smi_on_sys_activity;
    logic smi_on_hk_activity;
    logic auto_power;
  } padet_ctrl_t;

endpackage : padet_pkg

// File: rtl/padet_edge.sv
/*
  Samples a vector of activity levels on the clock and emits a one-cycle
  pulse for each low-to-high transition.
  Assumes inputs are synchronous to the clock.
*/
`timescale 1ns/10ps
module padet_edge #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] pulse_out
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] pulse_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          prev_reg[i] <= 1'b0;
          pulse_reg[i] <= 1'b0;
        end else begin
          prev_reg[i] <= level_in[i];
          pulse_reg[i] <= level_in[i] & ~prev_reg[i];
        end
      end
    end
  endgenerate

  assign pulse_out = pulse_reg;

endmodule : padet_edge

// File: rtl/padet_top.sv
/*
  Power activity detection unit: enable registers behind an index/data
  port pair, address range 0 comparator, system and house-keeping
  activity qualification, peripheral inactivity and access trapping.
  Assumes the power-down timers, SMI control/status registers and power
  state machine live outside and use the pulses produced here.
*/
// Operation
// - A range 0 hit counts as system activity only while its system enable bit 5 is set.
// - System enable bits 7, 6 and 5 enable interrupt lines 15-1, line 0 and the NMI.
// - House-keeping activity is recognised only in the doze or standby state.
// - An enabled house-keeping activity returns to power-on for the house-keeping time.
// - House-keeping enable bits 7 to 2 select DMA, bus master, keyboard, UPPER_INTERRUPT_LINES_SRC, IRQ0, NMI.
// - House-keeping range enable bit 5 makes a range 0 hit a house-keeping activity.
// - An enabled peripheral idle for a whole peripheral timeout period raises an SMI.
// - An access to a peripheral enabled in the trap register is trapped and raises an SMI.
// - The upper range byte meets address bits 31-24 on memory or 15-8 on IO cycles.
// - All enable and range registers reset to zero.
// - System activity reloads the timers and raises an SMI or wakes to power-on; the code wakes only with SMI_CTRL.auto_power set in doze or standby.
// - House-keeping activity raises an SMI if so configured, else enters house-keeping.
// - Lower range bit 0 selects memory compare when one and IO compare when zero.
`timescale 1ns/10ps
module padet_top
  import padet_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  input wire padet_pkg::padet_src_t ACT_SRC,
  input wire padet_pkg::padet_cycle_t PCI_CYCLE,
  input wire padet_pkg::padet_power_t POWER_STATE,
  input wire padet_pkg::padet_ctrl_t SMI_CTRL,
  input wire logic PERIPH_TIMEOUT,
  output logic TIMER_RELOAD,
  output logic WAKE_POWER_ON,
  output logic HK_ENTER,
  output logic SMI_REQ,
  output logic [7:0] INACTIVE_STATUS,
  output logic [7:0] TRAP_STATUS
);
  import padet_pkg::*;

  logic [7:0] index_reg;
  logic [7:0] sys_range_reg;
  logic [7:0] sys_irq_reg;
  logic [7:0] hk_src_reg;
  logic [7:0] hk_range_reg;
  logic [7:0] inact_reg;
  logic [7:0] trap_reg;
  logic [7:0] trap_up_reg;
  logic [7:0] range_hi_reg;
  logic [7:0] range_lo_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] seen_reg;
  logic [7:0] inact_stat_reg;
  logic [7:0] trap_stat_reg;
  logic reload_reg;
  logic wake_reg;
  logic hk_reg;
  logic smi_reg;
  logic range_hit_zero_reg;

  logic data_wr;
  logic [NUM_SRC-1:0] src_level;
  logic [NUM_SRC-1:0] src_evt;
  logic [7:0] range_field;
  logic [7:0] periph_evt;
  logic upper_irq_evt;
  logic sys_evt;
  logic hk_evt;
  logic low_power;
  logic [7:0] idle_hit;
  logic [7:0] trap_hit;

  assign data_wr = IO_WR && (IO_ADDR == PORT_DATA);

  // Index port
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      index_reg <= REG_RESET;
    end else if (IO_WR && (IO_ADDR == PORT_INDEX)) begin
      index_reg <= IO_WDATA;
    end
  end

  // Enable registers, reserved bits kept at zero
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sys_range_reg <= REG_RESET;
      sys_irq_reg <= REG_RESET;
      hk_src_reg <= REG_RESET;
      hk_range_reg <= REG_RESET;
      inact_reg <= REG_RESET;
      trap_reg <= REG_RESET;
      trap_up_reg <= REG_RESET;
      range_hi_reg <= REG_RESET;
      range_lo_reg <= REG_RESET;
    end else if (data_wr) begin
      unique case (index_reg)
        IDX_SYS_RANGE: sys_range_reg <= IO_WDATA & MASK_SYS_RANGE;
        IDX_SYS_IRQ: sys_irq_reg <= IO_WDATA & MASK_SYS_IRQ;
        IDX_HK_SRC: hk_src_reg <= IO_WDATA & MASK_HK_SRC;
        IDX_HK_RANGE: hk_range_reg <= IO_WDATA & MASK_HK_RANGE;
        IDX_INACT: inact_reg <= IO_WDATA & MASK_PERIPH;
        IDX_TRAP: trap_reg <= IO_WDATA & MASK_PERIPH;
        IDX_TRAP_UP: trap_up_reg <= IO_WDATA & MASK_TRAP_UP;
        IDX_RANGE_HI: range_hi_reg <= IO_WDATA & MASK_FULL;
        IDX_RANGE_LO: range_lo_reg <= IO_WDATA & MASK_FULL;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped indexes read 00h
  always_comb begin
    rdata_next = REG_RESET;
    if (IO_ADDR == PORT_INDEX) begin
      rdata_next = index_reg;
    end else if (IO_ADDR == PORT_DATA) begin
      unique case (index_reg)
        IDX_SYS_RANGE: rdata_next = sys_range_reg;
        IDX_SYS_IRQ: rdata_next = sys_irq_reg;
        IDX_HK_SRC: rdata_next = hk_src_reg;
        IDX_HK_RANGE: rdata_next = hk_range_reg;
        IDX_INACT: rdata_next = inact_reg;
        IDX_TRAP: rdata_next = trap_reg;
        IDX_TRAP_UP: rdata_next = trap_up_reg;
        IDX_RANGE_HI: rdata_next = range_hi_reg;
        IDX_RANGE_LO: rdata_next = range_lo_reg;
        default: rdata_next = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= REG_RESET;
    end else if (IO_RD) begin
      rdata_reg <= rdata_next;
    end
  end

  // Address range 0 compare on the bus cycle
  always_comb begin
    if (range_lo_reg[BIT_RANGE_MEM]) begin
      range_field = PCI_CYCLE.addr[31:24];
    end else begin
      range_field = PCI_CYCLE.addr[15:8];
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      range_hit_zero_reg <= 1'b0;
    end else begin
      range_hit_zero_reg <= PCI_CYCLE.valid
        && (PCI_CYCLE.is_mem == range_lo_reg[BIT_RANGE_MEM])
        && (range_field == range_hi_reg);
    end
  end

  // Source sampling into one-cycle events
  assign src_level = {ACT_SRC.upper_interrupt_lines_src, ACT_SRC.nmi_src, ACT_SRC.irq0_src,
                      ACT_SRC.drq_src, ACT_SRC.bus_master_src, ACT_SRC.parallel_port_src,
                      ACT_SRC.serial_port_src, ACT_SRC.keyboard_src, ACT_SRC.floppy_src,
                      ACT_SRC.hard_disk_src};

  padet_edge #(
    .WIDTH(NUM_SRC)
  ) padet_edge_i (
    .clk(MCLK),
    .rst(RESET),
    .level_in(src_level),
    .pulse_out(src_evt)
  );

  assign upper_irq_evt = |src_evt[SRC_UPPER_IRQ_HI:SRC_UPPER_IRQ_LO];

  // Peripheral events in the inactivity/trap bit order
  always_comb begin
    periph_evt = 8'h00;
    periph_evt[BIT_PER_PARALLEL] = src_evt[SRC_PARALLEL];
    periph_evt[BIT_PER_SERIAL] = src_evt[SRC_SERIAL];
    periph_evt[BIT_PER_KEYBOARD] = src_evt[SRC_KEYBOARD];
    periph_evt[BIT_PER_FLOPPY] = src_evt[SRC_FLOPPY];
    periph_evt[BIT_PER_HARD_DISK] = src_evt[SRC_HARD_DISK];
    periph_evt[BIT_PER_RANGE] = range_hit_zero_reg;
  end

  // Masked system activity
  assign sys_evt = (sys_range_reg[BIT_RANGE_EN] && range_hit_zero_reg)
    || (sys_irq_reg[BIT_SYS_UPPER_IRQ] && upper_irq_evt)
    || (sys_irq_reg[BIT_SYS_IRQ0] && src_evt[SRC_IRQ0])
    || (sys_irq_reg[BIT_SYS_NMI] && src_evt[SRC_NMI]);

  assign low_power = (POWER_STATE == PADET_PWR_DOZE) || (POWER_STATE == PADET_PWR_STANDBY);

  // Masked house-keeping activity, only in doze or standby
  assign hk_evt = low_power && (
    (hk_src_reg[BIT_HK_DRQ] && src_evt[SRC_DRQ])
    || (hk_src_reg[BIT_HK_BUS_MASTER] && src_evt[SRC_BUS_MASTER])
    || (hk_src_reg[BIT_HK_KEYBOARD] && src_evt[SRC_KEYBOARD])
    || (hk_src_reg[BIT_HK_UPPER_IRQ] && upper_irq_evt)
    || (hk_src_reg[BIT_HK_IRQ0] && src_evt[SRC_IRQ0])
    || (hk_src_reg[BIT_HK_NMI] && src_evt[SRC_NMI])
    || (hk_range_reg[BIT_RANGE_EN] && range_hit_zero_reg));

  // Activity seen within the current peripheral period
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      seen_reg <= REG_RESET;
    end else if (PERIPH_TIMEOUT) begin
      seen_reg <= periph_evt;
    end else begin
      seen_reg <= seen_reg | periph_evt;
    end
  end

  assign idle_hit = PERIPH_TIMEOUT ? (inact_reg & ~seen_reg & ~periph_evt) : 8'h00;
  assign trap_hit = trap_reg & periph_evt;

  // Sticky per-peripheral status, cleared by a write to the enable register
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      inact_stat_reg <= REG_RESET;
      trap_stat_reg <= REG_RESET;
    end else begin
      if (data_wr && (index_reg == IDX_INACT)) begin
        inact_stat_reg <= idle_hit;
      end else begin
        inact_stat_reg <= inact_stat_reg | idle_hit;
      end
      if (data_wr && (index_reg == IDX_TRAP)) begin
        trap_stat_reg <= trap_hit;
      end else begin
        trap_stat_reg <= trap_stat_reg | trap_hit;
      end
    end
  end

  // Activity responses
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      reload_reg <= 1'b0;
      wake_reg <= 1'b0;
      hk_reg <= 1'b0;
      smi_reg <= 1'b0;
    end else begin
      reload_reg <= sys_evt;
      wake_reg <= sys_evt && !SMI_CTRL.smi_on_sys_activity && SMI_CTRL.auto_power
        && low_power;
      hk_reg <= hk_evt && !SMI_CTRL.smi_on_hk_activity;
      smi_reg <= (sys_evt && SMI_CTRL.smi_on_sys_activity)
        || (hk_evt && SMI_CTRL.smi_on_hk_activity)
        || (|idle_hit)
        || (|trap_hit);
    end
  end

  assign IO_RDATA = rdata_reg;
  assign TIMER_RELOAD = reload_reg;
  assign WAKE_POWER_ON = wake_reg;
  assign HK_ENTER = hk_reg;
  assign SMI_REQ = smi_reg;
  assign INACTIVE_STATUS = inact_stat_reg;
  assign TRAP_STATUS = trap_stat_reg;

endmodule : padet_top

// File: tb/padet_monitor.sv
/*
  Port checker for padet_top: reset state, event-to-output relations,
  status-to-SMI timing and reserved read bits.
  Assumes it is bound to padet_top and that MCLK is the only clock.
*/
`timescale 1ns/10ps
module padet_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire padet_pkg::padet_src_t ACT_SRC,
  input wire padet_pkg::padet_power_t POWER_STATE,
  input wire logic PERIPH_TIMEOUT,
  input wire logic TIMER_RELOAD,
  input wire logic WAKE_POWER_ON,
  input wire logic HK_ENTER,
  input wire logic SMI_REQ,
  input wire logic [7:0] INACTIVE_STATUS,
  input wire logic [7:0] TRAP_STATUS
);
  import padet_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  logic [7:0] idx_reg;
  logic [7:0] irq_en_reg;

  // Shadow of the index and the interrupt enables
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      idx_reg <= 8'h00;
      irq_en_reg <= 8'h00;
    end else if (IO_WR && IO_ADDR == PORT_INDEX) begin
      idx_reg <= IO_WDATA;
    end else if (IO_WR && IO_ADDR == PORT_DATA && idx_reg == IDX_SYS_IRQ) begin
      irq_en_reg <= IO_WDATA;
    end
  end

  reset_clear_a: assert property (
    $fell(RESET) |-> IO_RDATA == 8'h00 && TRAP_STATUS == 8'h00 && !SMI_REQ
      && INACTIVE_STATUS == 8'h00)
    else $error("Outputs not clear after reset");
  nmi_reload_a: assert property (
    $rose(ACT_SRC.nmi_src) && irq_en_reg[BIT_SYS_NMI] |-> ##[1:3] TIMER_RELOAD)
    else $error("Enabled NMI gave no timer reload");
  wake_reload_a: assert property (
    WAKE_POWER_ON |-> TIMER_RELOAD
      && $past(POWER_STATE) inside {PADET_PWR_DOZE, PADET_PWR_STANDBY})
    else $error("Wake without timer reload");
  hk_state_a: assert property (
    HK_ENTER |-> $past(POWER_STATE) inside {PADET_PWR_DOZE, PADET_PWR_STANDBY})
    else $error("House-keeping entry outside doze or standby");
  inact_time_a: assert property (
    $rose(|INACTIVE_STATUS) |-> $past(PERIPH_TIMEOUT))
    else $error("Inactivity flagged without timeout");
  inact_smi_a: assert property (
    $rose(|INACTIVE_STATUS) |-> ##[0:1] SMI_REQ)
    else $error("Inactivity without SMI");
  trap_smi_a: assert property (
    $rose(|TRAP_STATUS) |-> ##[0:1] SMI_REQ)
    else $error("Trap without SMI");
  rd_reserved_a: assert property (
    $past(IO_RD) && $past(IO_ADDR) == PORT_DATA && idx_reg == IDX_SYS_RANGE
      |-> (IO_RDATA & ~MASK_SYS_RANGE) == 8'h00)
    else $error("Reserved bits read back set");
endmodule : padet_monitor

// File: tb/padet_src_model.sv
/*
  Activity source model: on go it raises the given source levels for two
  cycles and issues one bus cycle, then shows noise on the idle bus.
  Assumes go is driven by non-blocking assignment at the falling edge.
*/
`timescale 1ns/10ps
module padet_src_model (
  input wire logic clk,
  input wire logic go,
  input wire padet_pkg::padet_src_t pat,
  input wire padet_pkg::padet_cycle_t cyc,
  output padet_pkg::padet_src_t act_src,
  output padet_pkg::padet_cycle_t pci_cycle
);
  import padet_pkg::*;
  int hold = 0;
  always @(negedge clk) begin
    if (go) begin
      act_src <= pat;
      pci_cycle <= cyc;
      hold <= 2;
    end else begin
      pci_cycle <= {1'b0, ~pci_cycle.is_mem, ~pci_cycle.addr};
      if (hold <= 1) begin
        act_src <= '0;
      end
      if (hold > 0) begin
        hold <= hold - 1;
      end
    end
  end
endmodule : padet_src_model

// File: tb/padet_top_test.sv
/*
  Self-checking bench for padet_top: register access, system and
  house-keeping activity, range compare, inactivity and trapping.
  Assumes padet_monitor and padet_src_model are compiled alongside.
*/
`timescale 1ns/10ps
module padet_top_test;
  import padet_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, inactive_status, trap_status;
  logic timer_reload, wake_power_on, hk_enter, smi_req;
  padet_src_t act_src, pat = '0;
  padet_cycle_t pci_cycle, cyc = '0;
  padet_power_t power_state = PADET_PWR_DOZE;
  padet_ctrl_t smi_ctrl = 3'b001;
  logic periph_timeout = 1'b0;
  logic go = 1'b0;
  int fails = 0;
  int compares = 0;
  logic [7:0] masks [10] = '{8'h20, 8'hE0, 8'hFC, 8'h20, 8'hFC, 8'h00, 8'hFC, 8'h3F, 8'hFF,
    8'hFF};
  int hk_bits [6] = '{SRC_DRQ, SRC_BUS_MASTER, SRC_KEYBOARD, SRC_UPPER_IRQ_LO, SRC_IRQ0, SRC_NMI};

  always #4 mclk = ~mclk;

  padet_top padet_top_i (.MCLK(mclk), .RESET(reset), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .ACT_SRC(act_src),
    .PCI_CYCLE(pci_cycle), .POWER_STATE(power_state), .SMI_CTRL(smi_ctrl),
    .PERIPH_TIMEOUT(periph_timeout), .TIMER_RELOAD(timer_reload),
    .WAKE_POWER_ON(wake_power_on), .HK_ENTER(hk_enter), .SMI_REQ(smi_req),
    .INACTIVE_STATUS(inactive_status), .TRAP_STATUS(trap_status));
  padet_src_model padet_src_model_i (.clk(mclk), .go(go), .pat(pat), .cyc(cyc),
    .act_src(act_src), .pci_cycle(pci_cycle));

  function automatic padet_src_t src(input int b);
    return padet_src_t'(24'h000001 << b);
  endfunction : src
  function automatic padet_cycle_t pci(input logic m, input logic [31:0] a);
    return {1'b1, m, a};
  endfunction : pci

  task results;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task port_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask : port_wr
  task reg_wr(input logic [7:0] i, input logic [7:0] d);
    port_wr(PORT_INDEX, i);
    port_wr(PORT_DATA, d);
  endtask : reg_wr
  task reg_rd(input logic [7:0] i, input logic [7:0] exp);
    port_wr(PORT_INDEX, i);
    @(negedge mclk);
    io_addr = PORT_DATA;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    chk(io_rdata, exp);
  endtask : reg_rd
  // One event, then output pulses counted over six cycles
  task fire(input padet_src_t p, input padet_cycle_t c, input int r, w, h, s);
    int n [4];
    n = '{0, 0, 0, 0};
    @(negedge mclk);
    pat <= p;
    cyc <= c;
    go <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    repeat (6) begin
      @(negedge mclk);
      n[0] += int'(timer_reload !== 1'b0);
      n[1] += int'(wake_power_on !== 1'b0);
      n[2] += int'(hk_enter !== 1'b0);
      n[3] += int'(smi_req !== 1'b0);
    end
    chk(8'(n[0]), 8'(r));
    chk(8'(n[1]), 8'(w));
    chk(8'(n[2]), 8'(h));
    chk(8'(n[3]), 8'(s));
  endtask : fire
  task tmo;
    @(negedge mclk);
    periph_timeout = 1'b1;
    @(negedge mclk);
    periph_timeout = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : tmo

  initial begin
    #200000;
    fails++;
    $display("Error at %0t: run timed out", $time);
    results();
  end

  initial begin
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 10; i++) reg_rd(8'h63 + 8'(i), 8'h00);
    for (int i = 0; i < 10; i++) begin
      reg_wr(8'h63 + 8'(i), 8'hFF);
      reg_rd(8'h63 + 8'(i), masks[i]);
      reg_wr(8'h63 + 8'(i), 8'h00);
    end
    reg_wr(IDX_SYS_IRQ, 8'hE0);
    fire(src(SRC_NMI), '0, 1, 1, 0, 0);
    fire(src(SRC_IRQ0), '0, 1, 1, 0, 0);
    fire(src(SRC_UPPER_IRQ_HI), '0, 1, 1, 0, 0);
    power_state = PADET_PWR_ON;
    fire(src(SRC_NMI), '0, 1, 0, 0, 0);
    power_state = PADET_PWR_DOZE;
    smi_ctrl = 3'b000;
    fire(src(SRC_IRQ0), '0, 1, 0, 0, 0);
    smi_ctrl = 3'b100;
    fire(src(SRC_NMI), '0, 1, 0, 0, 1);
    smi_ctrl = 3'b001;
    reg_wr(IDX_SYS_IRQ, 8'h00);
    fire(src(SRC_IRQ0), '0, 0, 0, 0, 0);
    reg_wr(IDX_SYS_RANGE, 8'h20);
    reg_wr(IDX_RANGE_HI, 8'h12);
    reg_wr(IDX_RANGE_LO, 8'h01);
    fire('0, pci(1'b1, 32'h12345678), 1, 1, 0, 0);
    fire('0, pci(1'b1, 32'h13001200), 0, 0, 0, 0);
    reg_wr(IDX_RANGE_LO, 8'h00);
    fire('0, pci(1'b0, 32'h00001234), 1, 1, 0, 0);
    fire('0, pci(1'b0, 32'h12000000), 0, 0, 0, 0);
    reg_wr(IDX_SYS_RANGE, 8'h00);
    fire('0, pci(1'b0, 32'h00001234), 0, 0, 0, 0);
    reg_wr(IDX_HK_SRC, 8'hFC);
    foreach (hk_bits[i]) fire(src(hk_bits[i]), '0, 0, 0, 1, 0);
    power_state = PADET_PWR_ON;
    fire(src(SRC_DRQ), '0, 0, 0, 0, 0);
    power_state = PADET_PWR_SUSPEND;
    fire(src(SRC_NMI), '0, 0, 0, 0, 0);
    power_state = PADET_PWR_HOUSEKEEP;
    fire(src(SRC_IRQ0), '0, 0, 0, 0, 0);
    power_state = PADET_PWR_STANDBY;
    smi_ctrl = 3'b010;
    fire(src(SRC_BUS_MASTER), '0, 0, 0, 0, 1);
    smi_ctrl = 3'b001;
    reg_wr(IDX_HK_SRC, 8'h00);
    fire(src(SRC_DRQ), '0, 0, 0, 0, 0);
    reg_wr(IDX_HK_RANGE, 8'h20);
    fire('0, pci(1'b0, 32'h00001234), 0, 0, 1, 0);
    reg_wr(IDX_HK_RANGE, 8'h00);
    reg_wr(IDX_INACT, 8'h80);
    tmo();
    tmo();
    chk(inactive_status, 8'h80);
    reg_wr(IDX_INACT, 8'h80);
    fire(src(SRC_PARALLEL), '0, 0, 0, 0, 0);
    tmo();
    chk(inactive_status, 8'h00);
    reg_wr(IDX_TRAP, 8'h40);
    fire(src(SRC_SERIAL), '0, 0, 0, 0, 1);
    fire(src(SRC_KEYBOARD), '0, 0, 0, 0, 0);
    chk(trap_status, 8'h40);
    reg_wr(IDX_TRAP, 8'h04);
    fire('0, pci(1'b0, 32'h00001234), 0, 0, 0, 1);
    chk(trap_status, 8'h04);
    results();
  end
endmodule : padet_top_test

bind padet_top padet_monitor padet_monitor_i (.MCLK(MCLK), .RESET(RESET), .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .ACT_SRC(ACT_SRC),
  .POWER_STATE(POWER_STATE), .PERIPH_TIMEOUT(PERIPH_TIMEOUT), .TIMER_RELOAD(TIMER_RELOAD),
  .WAKE_POWER_ON(WAKE_POWER_ON), .HK_ENTER(HK_ENTER), .SMI_REQ(SMI_REQ),
  .INACTIVE_STATUS(INACTIVE_STATUS), .TRAP_STATUS(TRAP_STATUS));
